// [verilog/slow_osc_ctrl.v]
// slow external oscillator control, failure detector, rtc source and clock output
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`include "slow_osc_map.vh"

// Functional notes
// R1: osc_enable at bit 8 starts the slow oscillator, clearing it stops it.
// R2: hardware sets read-only osc_ready at bit 9 once the oscillator is stable.
// R3: oscillator clock is gated off until osc_ready is set.
// R4: osc_ready rising with ready enable at interrupt bit 8 raises an interrupt.
// R5: bypass plus enable skips the amplifier; slow output pin left undriven.
// R6: in bypass the external source drives a near 50% duty clock.
// R7: software sets security_enable; only reset, rtc soft reset or failure clear it.
// R8: software sets security_enable only after both oscillators ready and rtc source chosen.
// R9: failure detector runs in run, sleep, stop and standby.
// R10: on failure slow clock is withdrawn from rtc; no register field changes (here security_enable clears and sec_fail_q sets).
// R11: on failure a wakeup in standby, otherwise an interrupt.
// R12: after failure software clears security_enable and osc_enable, may reselect rtc.
// R13: clock output divides selected source by 1, 2, 4, 8 or 16.
// R14: 3-bit clk_out_select picks one of seven clock output sources.
// R15: rtc from slow external or internal slow keeps running in stop and standby.
// R16: rtc from fast external is not usable in stop or standby.
// R17: software clears osc_enable and osc_bypass before changing configuration.
// R18: osc_bypass and osc_enable may be set in the same write.
// R19: software polls osc_ready after enabling with a crystal.
// R20: osc_ready clears when osc_enable is cleared.
module slow_osc_ctrl #(
    parameter FAIL_TIMEOUT = `FAIL_TIMEOUT_CYC
) (
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_q,
    output reg         pready_q,
    output reg         pslverr_q,
    // oscillator pins
    input  wire        slow_input_pin,
    output reg         slow_output_pin_q,
    output reg         slow_output_oe_q,
    output reg         amp_enable_q,
    // other clock sources, sampled: sys, fast rc, multi-speed, fast ext, pll
    input  wire [4:0]  other_clk_pins,
    input  wire        internal_slow_pin,
    // power state
    input  wire [1:0]  power_mode,
    // outputs to the system
    output reg         slow_clk_q,
    output reg         rtc_clk_q,
    output reg         irq_q,
    output reg         wakeup_q,
    output reg         clk_out_pin_q
);
    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    wire [6:0] src_pin;
    wire [6:0] src_lvl;
    wire [6:0] src_rise;
    assign src_pin = {slow_input_pin, internal_slow_pin, other_clk_pins};

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_sync
            pin_sync u_sync (
                .pclk    (pclk),
                .presetn (presetn),
                .pin     (src_pin[gi]),
                .level_q (src_lvl[gi]),
                .rise_q  (src_rise[gi])
            );
        end
    endgenerate

    wire slow_lvl  = src_lvl[6];
    wire slow_rise = src_rise[6];
    wire int_rise  = src_rise[5];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg        int_slow_en_q;
    reg        int_slow_rdy_q;
    reg        osc_enable_q;
    reg        osc_ready_q;
    reg        osc_bypass_q;
    reg        sec_enable_q;
    reg        sec_fail_q;
    reg [1:0]  rtc_sel_q;
    reg        rtc_soft_rst_q;
    reg        rdy_flag_q;
    reg        fail_flag_q;
    reg        rdy_ie_q;
    reg        fail_ie_q;
    reg [2:0]  out_sel_q;
    reg [2:0]  out_pre_q;
    reg [7:0]  edge_cnt_q;
    reg [31:0] idle_cnt_q;
    reg [3:0]  div_cnt_q;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire access   = psel & penable & pready_q;
    wire wr       = access & pwrite;
    wire hit_cs   = (paddr == `ADDR_CTRL_STATUS);
    wire hit_ci   = (paddr == `ADDR_INT_CTRL);
    wire hit_cf   = (paddr == `ADDR_CLK_CONFIG);
    wire mapped   = hit_cs | hit_ci | hit_cf;
    wire wr_cs    = wr & hit_cs;
    wire wr_ci    = wr & hit_ci;
    wire wr_cf    = wr & hit_cf;

    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0000_0000;
        if (hit_cs) begin
            rd_d[`CS_INT_SLOW_EN]                   = int_slow_en_q;
            rd_d[`CS_INT_SLOW_RDY]                  = int_slow_rdy_q;
            rd_d[`CS_OSC_ENABLE]                    = osc_enable_q;
            rd_d[`CS_OSC_READY]                     = osc_ready_q;
            rd_d[`CS_OSC_BYPASS]                    = osc_bypass_q;
            rd_d[`CS_SEC_ENABLE]                    = sec_enable_q;
            rd_d[`CS_SEC_FAIL]                      = sec_fail_q;
            rd_d[`CS_RTC_SEL_LO+1:`CS_RTC_SEL_LO]   = rtc_sel_q;
            rd_d[`CS_RTC_SOFT_RST]                  = rtc_soft_rst_q;
        end else if (hit_ci) begin
            rd_d[`CI_RDY_FLAG]                      = rdy_flag_q;
            rd_d[`CI_FAIL_FLAG]                     = fail_flag_q;
            rd_d[`CI_RDY_IE]                        = rdy_ie_q;
            rd_d[`CI_FAIL_IE]                       = fail_ie_q;
        end else if (hit_cf) begin
            rd_d[`CF_OUT_SEL_LO+2:`CF_OUT_SEL_LO]   = out_sel_q;
            rd_d[`CF_OUT_PRE_LO+2:`CF_OUT_PRE_LO]   = out_pre_q;
        end
    end

    // one wait state so all bus outputs come from flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~mapped;
            if (psel & penable & ~pready_q & ~pwrite)
                prdata_q <= rd_d;
        end
    end

    // ----------------------------------------
    // oscillator enable and stabilisation
    // ----------------------------------------
    // a fixed count of clean edges stands in for the analog settling time
    wire startup_done = (edge_cnt_q == `STARTUP_EDGES);
    // detector trips only while armed and the oscillator was good
    wire fail_evt = sec_enable_q & osc_ready_q & ~sec_fail_q &
                    (idle_cnt_q == FAIL_TIMEOUT - 1);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_slow_en_q  <= 1'b0;
            osc_enable_q   <= 1'b0;
            osc_bypass_q   <= 1'b0;
            rtc_sel_q      <= `RTC_SRC_NONE;
            rtc_soft_rst_q <= 1'b0;
            out_sel_q      <= 3'h0;
            out_pre_q      <= 3'h0;
            rdy_ie_q       <= 1'b0;
            fail_ie_q      <= 1'b0;
        end else begin
            if (wr_cs) begin
                int_slow_en_q  <= pwdata[`CS_INT_SLOW_EN];
                osc_enable_q   <= pwdata[`CS_OSC_ENABLE]; // R1 R18
                osc_bypass_q   <= pwdata[`CS_OSC_BYPASS]; // R18
                rtc_sel_q      <= pwdata[`CS_RTC_SEL_LO+1:`CS_RTC_SEL_LO];
                rtc_soft_rst_q <= pwdata[`CS_RTC_SOFT_RST];
            end
            if (wr_ci) begin
                rdy_ie_q  <= pwdata[`CI_RDY_IE];
                fail_ie_q <= pwdata[`CI_FAIL_IE];
            end
            if (wr_cf) begin
                out_sel_q <= pwdata[`CF_OUT_SEL_LO+2:`CF_OUT_SEL_LO];
                out_pre_q <= pwdata[`CF_OUT_PRE_LO+2:`CF_OUT_PRE_LO];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_cnt_q     <= 8'h00;
            osc_ready_q    <= 1'b0;
            int_slow_rdy_q <= 1'b0;
        end else begin
            if (!osc_enable_q) begin
                edge_cnt_q  <= 8'h00;
                osc_ready_q <= 1'b0; // R20
            end else begin
                if (slow_rise && !startup_done)
                    edge_cnt_q <= edge_cnt_q + 8'h01;
                if (startup_done)
                    osc_ready_q <= 1'b1; // R2
            end
            if (!int_slow_en_q)
                int_slow_rdy_q <= 1'b0;
            else if (int_rise)
                int_slow_rdy_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // amplifier and output pin
    // ----------------------------------------
    // in bypass the feedback pin floats so the external clock is not loaded
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp_enable_q      <= 1'b0;
            slow_output_oe_q  <= 1'b0;
            slow_output_pin_q <= 1'b0;
            slow_clk_q        <= 1'b0;
        end else begin
            amp_enable_q      <= osc_enable_q & ~osc_bypass_q; // R5
            slow_output_oe_q  <= osc_enable_q & ~osc_bypass_q; // R5
            slow_output_pin_q <= ~slow_lvl;
            slow_clk_q        <= slow_lvl & osc_ready_q; // R3
        end
    end

    // ----------------------------------------
    // failure detector
    // ----------------------------------------
    // no power-mode gating: the watchdog counter keeps running in every mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt_q   <= 32'h0000_0000;
            sec_enable_q <= 1'b0;
            sec_fail_q   <= 1'b0;
        end else begin
            if (slow_rise || !sec_enable_q)
                idle_cnt_q <= 32'h0000_0000;
            else if (idle_cnt_q != FAIL_TIMEOUT - 1)
                idle_cnt_q <= idle_cnt_q + 32'h0000_0001; // R9
            if (rtc_soft_rst_q || fail_evt)
                sec_enable_q <= 1'b0; // R7
            else if (wr_cs && pwdata[`CS_SEC_ENABLE])
                sec_enable_q <= 1'b1; // R7
            // status holds until software drops osc_enable
            if (fail_evt)
                sec_fail_q <= 1'b1;
            else if (!osc_enable_q)
                sec_fail_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // interrupt flags and wakeup
    // ----------------------------------------
    wire rdy_set = osc_enable_q & startup_done & ~osc_ready_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_flag_q  <= 1'b0;
            fail_flag_q <= 1'b0;
            irq_q       <= 1'b0;
            wakeup_q    <= 1'b0;
        end else begin
            // set wins over a clear in the same cycle
            if (rdy_set)
                rdy_flag_q <= 1'b1;
            else if (wr_ci && pwdata[`CI_RDY_CLR])
                rdy_flag_q <= 1'b0;
            if (fail_evt)
                fail_flag_q <= 1'b1;
            else if (wr_ci && pwdata[`CI_FAIL_CLR])
                fail_flag_q <= 1'b0;
            irq_q <= (rdy_flag_q & rdy_ie_q) | // R4
                     (fail_flag_q & fail_ie_q & (power_mode != `PWR_STANDBY)); // R11
            wakeup_q <= fail_evt & (power_mode == `PWR_STANDBY); // R11
        end
    end

    // ----------------------------------------
    // rtc clock source
    // ----------------------------------------
    // a fast crystal is stopped in deep modes, so it cannot keep the rtc alive
    wire deep = (power_mode == `PWR_STOP) | (power_mode == `PWR_STANDBY);
    reg  rtc_d;
    always @* begin
        case (rtc_sel_q)
            `RTC_SRC_SLOW_EXT: rtc_d = slow_lvl & osc_ready_q & ~sec_fail_q; // R10 R15
            `RTC_SRC_INT_SLOW: rtc_d = src_lvl[5] & int_slow_rdy_q; // R15
            `RTC_SRC_FAST_EXT: rtc_d = src_lvl[3] & ~deep; // R16
            default:           rtc_d = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rtc_clk_q <= 1'b0;
        else
            rtc_clk_q <= rtc_d & ~rtc_soft_rst_q;
    end

    // ----------------------------------------
    // clock output path
    // ----------------------------------------
    // source index 7 is the gated slow oscillator, never the raw pin
    wire [7:0] out_lvl  = {slow_lvl & osc_ready_q, src_lvl[5:0], 1'b0};
    wire [7:0] out_rise = {slow_rise & osc_ready_q, src_rise[5:0], 1'b0};
    wire       sel_lvl  = out_lvl[out_sel_q]; // R14
    wire       sel_rise = out_rise[out_sel_q]; // R14
    // toggle every half period; codes above 4 are treated as divide by 16
    wire [2:0] pre_eff  = (out_pre_q > 3'h4) ? 3'h4 : out_pre_q;
    wire [3:0] half     = (pre_eff == 3'h0) ? 4'h0 : ((4'h1 << (pre_eff - 3'h1)) - 4'h1);
    // edges are counted after the synchroniser, so the output carries one pclk of jitter

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q     <= 4'h0;
            clk_out_pin_q <= 1'b0;
        end else if (out_sel_q == 3'h0) begin
            div_cnt_q     <= 4'h0;
            clk_out_pin_q <= 1'b0;
        end else if (pre_eff == 3'h0) begin
            clk_out_pin_q <= sel_lvl; // R13
        end else if (sel_rise) begin
            if (div_cnt_q >= half) begin
                div_cnt_q     <= 4'h0;
                clk_out_pin_q <= ~clk_out_pin_q; // R13
            end else begin
                div_cnt_q <= div_cnt_q + 4'h1;
            end
        end
    end
endmodule // slow_osc_ctrl

// [verilog/slow_osc_map.vh]
// register map, field positions and timing counts of the slow oscillator control
`ifndef SLOW_OSC_MAP_VH
`define SLOW_OSC_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ADDR_CTRL_STATUS      12'h000
`define ADDR_INT_CTRL         12'h004
`define ADDR_CLK_CONFIG       12'h008
// ----------------------------------------
// slow_osc_ctrl_status fields
// ----------------------------------------
`define CS_INT_SLOW_EN        0
`define CS_INT_SLOW_RDY       1
`define CS_OSC_ENABLE         8
`define CS_OSC_READY          9
`define CS_OSC_BYPASS         10
`define CS_SEC_ENABLE         11
`define CS_SEC_FAIL           12
`define CS_RTC_SEL_LO         16
`define CS_RTC_SOFT_RST       23
// ----------------------------------------
// clock_interrupt_ctrl fields
// ----------------------------------------
`define CI_RDY_FLAG           1
`define CI_FAIL_FLAG          6
`define CI_RDY_IE             8
`define CI_FAIL_IE            14
`define CI_RDY_CLR            17
`define CI_FAIL_CLR           22
// ----------------------------------------
// clock_configuration fields
// ----------------------------------------
`define CF_OUT_SEL_LO         24
`define CF_OUT_PRE_LO         28
// ----------------------------------------
// encodings
// ----------------------------------------
`define RTC_SRC_NONE          2'h0
`define RTC_SRC_SLOW_EXT      2'h1
`define RTC_SRC_INT_SLOW      2'h2
`define RTC_SRC_FAST_EXT      2'h3
`define PWR_RUN               2'h0
`define PWR_SLEEP             2'h1
`define PWR_STOP              2'h2
`define PWR_STANDBY           2'h3
// ----------------------------------------
// timing
// ----------------------------------------
`define PCLK_PERIOD_NS        10
`define STARTUP_EDGES         8'h10
`define FAIL_TIMEOUT_NS       100000
`define FAIL_TIMEOUT_CYC      (`FAIL_TIMEOUT_NS / `PCLK_PERIOD_NS)
`endif

// [verilog/pin_sync.v]
// three-stage synchroniser for a pin level with rising-edge pulse
`timescale 1ns/1ps
module pin_sync (
    // clock and reset
    input  wire pclk,
    input  wire presetn,
    // pin side
    input  wire pin,
    // synchronised side
    output reg  level_q,
    output reg  rise_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // change accepted only once stages two and three agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            level_q <= 1'b0;
            rise_q  <= 1'b0;
        end else begin
            s1_q   <= pin;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            rise_q <= 1'b0;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
                rise_q  <= s3_q & ~level_q;
            end
        end
    end
endmodule // pin_sync

// [bench/slow_osc_monitor.sv]
// assertion checker for the slow oscillator control block
`timescale 1ns/1ps
`include "slow_osc_map.vh"
module slow_osc_monitor #(
    parameter FAIL_TIMEOUT = 200
) (
    // apb
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata_q,
    input wire        pready_q,
    input wire        pslverr_q,
    // oscillator pins
    input wire        slow_input_pin,
    input wire        slow_output_pin_q,
    input wire        slow_output_oe_q,
    input wire        amp_enable_q,
    // other sources and power
    input wire [4:0]  other_clk_pins,
    input wire        internal_slow_pin,
    input wire [1:0]  power_mode,
    // system outputs
    input wire        slow_clk_q,
    input wire        rtc_clk_q,
    input wire        irq_q,
    input wire        wakeup_q,
    input wire        clk_out_pin_q
);
    // ----------------------------------------
    // shadows of completed writes
    // ----------------------------------------
    wire       wr_ok = psel & penable & pwrite & pready_q & ~pslverr_q;
    reg        en_q, byp_q, rie_q, fie_q, pin_q;
    reg  [1:0] rsel_q;
    reg  [2:0] osel_q;
    reg  [4:0] rise_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {en_q, byp_q, rie_q, fie_q, pin_q} <= 5'h0;
            rsel_q <= 2'h0;
            osel_q <= 3'h0;
            rise_q <= 5'h0;
        end else begin
            pin_q <= slow_input_pin;
            if (wr_ok && paddr == `ADDR_CTRL_STATUS) begin
                en_q   <= pwdata[8];
                byp_q  <= pwdata[10];
                rsel_q <= pwdata[17:16];
            end
            if (wr_ok && paddr == `ADDR_INT_CTRL) begin
                rie_q <= pwdata[`CI_RDY_IE];
                fie_q <= pwdata[`CI_FAIL_IE];
            end
            if (wr_ok && paddr == `ADDR_CLK_CONFIG)
                osel_q <= pwdata[26:24];
            // raw pin edges lead the synced count, so this bound is safe
            if (!en_q)
                rise_q <= 5'h0;
            else if (slow_input_pin && !pin_q && rise_q != 5'h1f)
                rise_q <= rise_q + 5'h1;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pready_one_cycle: assert property (pready_q |=> !pready_q) else $error("pready held too long");
    a_slverr_with_ready: assert property (pslverr_q |-> pready_q) else $error("pslverr without pready");
    a_enable_starts_amp: assert property (wr_ok && paddr == `ADDR_CTRL_STATUS && pwdata[8] && !pwdata[10]
        |-> ##[1:2] amp_enable_q) else $error("amplifier not started");
    a_disable_stops_all: assert property (!en_q && !$past(en_q) && !$past(en_q, 2)
        |-> !amp_enable_q && !slow_clk_q) else $error("oscillator not stopped");
    a_clock_after_ready: assert property ($rose(slow_clk_q) && en_q |-> rise_q >= 5'h10)
        else $error("slow clock released early");
    a_bypass_no_drive: assert property (en_q && byp_q && $past(en_q, 2) && $past(byp_q, 2)
        |-> !slow_output_oe_q && !amp_enable_q) else $error("bypass still drives");
    a_irq_has_cause: assert property ($rose(irq_q) |-> $past(rie_q) || $past(fie_q))
        else $error("interrupt without enable");
    a_wakeup_standby: assert property (wakeup_q |-> $past(power_mode) == `PWR_STANDBY ##1 !wakeup_q)
        else $error("wakeup outside standby");
    a_fail_withdraws_rtc: assert property (wakeup_q |-> ##2 !rtc_clk_q [*8])
        else $error("rtc clock after failure");
    a_fast_ext_low_power: assert property (rsel_q == `RTC_SRC_FAST_EXT && $past(rsel_q) == `RTC_SRC_FAST_EXT
        && power_mode[1] && $past(power_mode[1]) |-> !rtc_clk_q) else $error("rtc runs in stop");
    a_clk_out_off: assert property (osel_q == 3'h0 && $past(osel_q) == 3'h0 && $past(osel_q, 2) == 3'h0
        |-> !clk_out_pin_q) else $error("clock output not off");
endmodule // slow_osc_monitor
bind slow_osc_ctrl slow_osc_monitor #(.FAIL_TIMEOUT(FAIL_TIMEOUT)) mon_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .slow_input_pin(slow_input_pin), .slow_output_pin_q(slow_output_pin_q),
    .slow_output_oe_q(slow_output_oe_q), .amp_enable_q(amp_enable_q), .other_clk_pins(other_clk_pins),
    .internal_slow_pin(internal_slow_pin), .power_mode(power_mode), .slow_clk_q(slow_clk_q),
    .rtc_clk_q(rtc_clk_q), .irq_q(irq_q), .wakeup_q(wakeup_q), .clk_out_pin_q(clk_out_pin_q)
);

// [bench/slow_osc_source.sv]
// crystal or bypass clock source on the slow input pin
`timescale 1ns/1ps
module slow_osc_source #(
    parameter HALF_NS = 85
) (
    // control
    input  wire run,
    input  wire stall,
    // pin
    output reg  pin
);
    initial begin
        pin = 1'b0;
        #3;
        forever begin
            #HALF_NS;
            // a failed source sticks high, so a stuck level cannot pass for a clock
            if (stall)
                pin = 1'b1;
            else if (run)
                pin = ~pin;
        end
    end
endmodule // slow_osc_source

// [bench/slow_osc_ctrl_tb.sv]
// self-checking bench for the slow oscillator control block
`timescale 1ns/1ps
`include "slow_osc_map.vh"
module slow_osc_ctrl_tb;
    localparam FT = 200;
    reg         pclk, presetn, psel, penable, pwrite, byp, stall, err;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    reg  [1:0]  power_mode;
    reg  [5:0]  div;
    wire [31:0] prdata_q;
    wire        pready_q, pslverr_q, slow_input_pin, slow_output_pin_q, slow_output_oe_q, amp_enable_q;
    wire        slow_clk_q, rtc_clk_q, irq_q, wakeup_q, clk_out_pin_q;
    integer     num_errors, checked, cycles, i, n;
    slow_osc_ctrl #(.FAIL_TIMEOUT(FT)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .slow_input_pin(slow_input_pin), .slow_output_pin_q(slow_output_pin_q),
        .slow_output_oe_q(slow_output_oe_q), .amp_enable_q(amp_enable_q), .other_clk_pins(div[5:1]),
        .internal_slow_pin(div[4]), .power_mode(power_mode), .slow_clk_q(slow_clk_q),
        .rtc_clk_q(rtc_clk_q), .irq_q(irq_q), .wakeup_q(wakeup_q), .clk_out_pin_q(clk_out_pin_q));
    slow_osc_source src_u (.run(amp_enable_q | byp), .stall(stall), .pin(slow_input_pin));
    // ----------------------------------------
    // clock, sources, timeout
    // ----------------------------------------
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        div <= div + 6'h1;
        cycles = cycles + 1;
        if (cycles == 60000) begin
            num_errors = num_errors + 1;
            results;
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task results;
        begin
            $display("errors %0d checks %0d", num_errors, checked);
            if (num_errors == 0 && checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready_q !== 1'b1)
                @(posedge pclk);
            rd = prdata_q;
            err = pslverr_q;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task chk(input [32:0] g, input [32:0] e);
        begin
            checked = checked + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("unexpected at %0t: got %h want %h", $time, g, e);
            end
        end
    endtask
    task chk_near(input integer g, input integer e, input integer t);
        begin
            checked = checked + 1;
            if (((g >= e - t) && (g <= e + t)) !== 1'b1) begin
                num_errors = num_errors + 1;
                $display("unexpected at %0t: count %0d want %0d", $time, g, e);
            end
        end
    endtask
    task hi_count(input integer s, output integer c);
        integer k;
        begin
            c = 0;
            for (k = 0; k < 64; k = k + 1) begin
                @(posedge pclk);
                #1;
                c = c + (s == 0 ? slow_clk_q : (s == 1 ? rtc_clk_q : clk_out_pin_q));
            end
        end
    endtask
    task period(output integer p);
        time t0;
        begin
            @(posedge clk_out_pin_q);
            @(posedge clk_out_pin_q);
            t0 = $time;
            @(posedge clk_out_pin_q);
            p = ($time - t0) / 10;
        end
    endtask
    initial begin
        {pclk, presetn, psel, penable, pwrite, byp, stall, err} = 8'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        power_mode = `PWR_RUN;
        div = 6'h0;
        {num_errors, checked, cycles} = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `ADDR_CTRL_STATUS, 0);
        chk(rd, 32'h0000_0000);
        apb(0, 12'h00c, 0);
        chk({err, rd}, {1'b1, 32'h0000_0000});
        apb(1, `ADDR_INT_CTRL, 32'h0000_0100);
        apb(1, `ADDR_CTRL_STATUS, 32'h0000_0101);
        repeat (2) @(posedge pclk);
        #1;
        chk({amp_enable_q, slow_output_oe_q}, 2'b11);
        apb(0, `ADDR_CTRL_STATUS, 0);
        chk(rd[9], 1'b0);
        while (rd[9] !== 1'b1)
            apb(0, `ADDR_CTRL_STATUS, 0);
        repeat (2) @(posedge pclk);
        #1;
        chk(irq_q, 1'b1);
        hi_count(0, n);
        chk_near(n, 32, 4);
        apb(1, `ADDR_INT_CTRL, 32'h0002_0000);
        repeat (2) @(posedge pclk);
        #1;
        chk(irq_q, 1'b0);
        apb(1, `ADDR_CTRL_STATUS, 32'h0001_0101);
        apb(1, `ADDR_CTRL_STATUS, 32'h0001_0901);
        apb(1, `ADDR_CTRL_STATUS, 32'h0001_0101);
        apb(0, `ADDR_CTRL_STATUS, 0);
        chk(rd[11], 1'b1);
        power_mode <= `PWR_STANDBY;
        stall <= 1'b1;
        n = 0;
        while (wakeup_q !== 1'b1) begin
            @(posedge pclk);
            #1;
            n = n + 1;
        end
        chk_near(n, FT, 25);
        hi_count(1, n);
        chk(n, 0);
        apb(0, `ADDR_CTRL_STATUS, 0);
        chk(rd & 32'h0003_1901, 32'h0001_1101);
        apb(0, `ADDR_INT_CTRL, 0);
        chk(rd & 32'h0000_0142, 32'h0000_0040);
        apb(1, `ADDR_CTRL_STATUS, 32'h0002_0001);
        stall <= 1'b0;
        power_mode <= `PWR_STOP;
        apb(0, `ADDR_CTRL_STATUS, 0);
        chk(rd & 32'h0000_1300, 32'h0000_0000);
        hi_count(1, n);
        chk_near(n, 32, 4);
        apb(1, `ADDR_CTRL_STATUS, 32'h0003_0001);
        hi_count(1, n);
        chk(n, 0);
        power_mode <= `PWR_RUN;
        apb(1, `ADDR_CTRL_STATUS, 32'h0000_0501);
        byp <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        chk({amp_enable_q, slow_output_oe_q}, 2'b00);
        while (rd[9] !== 1'b1)
            apb(0, `ADDR_CTRL_STATUS, 0);
        for (i = 0; i < 5; i = i + 1) begin
            apb(1, `ADDR_CLK_CONFIG, {1'b0, i[2:0], 4'h7, 24'h00_0000});
            period(n);
            chk_near(n, 17 << i, 1);
        end
        // every source here toggles at half duty, so each selection but 0 (off, shows 0) shows 32 of 64
        for (i = 0; i < 8; i = i + 1) begin
            apb(1, `ADDR_CLK_CONFIG, {5'h00, i[2:0], 24'h00_0000});
            hi_count(2, n);
            chk_near(n, i == 0 ? 0 : 32, 4);
        end
        apb(1, `ADDR_CTRL_STATUS, 32'h0000_0000);
        apb(0, `ADDR_CTRL_STATUS, 0);
        chk(rd[9], 1'b0);
        results;
    end
endmodule // slow_osc_ctrl_tb
